// >>> hw/ccsc_defines.vh
// Purpose: constants for the charge count and sleep control block
// Assumes: 20 MHz core clock
// Notes:   times in their own unit; cycle counts derived below
`ifndef CCSC_DEFINES_VH
`define CCSC_DEFINES_VH
`define CCSC_CLK_HZ            20000000
// normal time counter period 0.8789 s, in microseconds
`define CCSC_TC_PERIOD_US      878900
`define CCSC_TC_CYCLES         ((`CCSC_CLK_HZ / 1000000) * `CCSC_TC_PERIOD_US)
// slow time counter period 225 s = 256 normal periods
`define CCSC_TC_SLOW_DIV       256
// one hour, in seconds and in core clocks; 20 MHz x 3600 s needs 37 bits,
// so the cycle count is sized here instead of overflowing integer arithmetic
`define CCSC_HOUR_S            3600
`define CCSC_HOUR_CYCLES       40'h10C388D000
// wake threshold codes; 3.05 uV per step
`define CCSC_WAKE_SEL_RESET    3'h7
`define CCSC_WAKE_SEL_OFF      3'h0
`define CCSC_SLEEP_ALLOW_RESET 1'b1
// temperature in quarter kelvin: 0 C, 25 C, 60 C
`define CCSC_TQ_0C             12'h445
`define CCSC_TQ_25C            12'h4A9
`define CCSC_TQ_60C            12'h535
`define CCSC_TQ_10DEG          12'h028
`endif

// >>> hw/ccsc_top.v
// Purpose: coulomb counting, time counters, self-discharge and sleep control
// Assumes: one clock core_clk 20 MHz; converter pulses already on core_clk
// Notes:   register access lives outside; counters and control are ports
// Behaviour
// - discharge pulses increment discharge accumulator
// - discharge time counter advances while discharging
// - charge pulses increment charge accumulator independently
// - charge time counter advances only while charging
// - time counters are 16 bits and wrap
// - wrap sets overflow flag, then 1/256 rate
// - period 0.8789 s normal, 225 s slow
// - self-discharge hourly at 25 C, doubles per 10 C
// - below 25 C rate halves per 10 C
// - sleep keeps only self-discharge, temperature and the hourly calibration strobe updating
// - idle-sleep needs low current, allow bit, idle hour
// - any line transition wakes sleeping device while pack-present is high
// - reset sets sleep-allow bit
// - wake threshold code 0 none, 1..7 thresholds
// - pack-present low forces sleep
// - pack rise wakes if allowed by history
// - pack rise ignored if asleep at fall and sleep-allow bit set
// - hourly offset calibration strobe, awake or asleep
// - clear bit returns to zero when done
// - time counter clear also clears its overflow
`timescale 1ns/100ps
`include "ccsc_defines.vh"
module ccsc_top #(
  parameter TC_CYCLES   = `CCSC_TC_CYCLES,
  parameter HOUR_CYCLES = `CCSC_HOUR_CYCLES,
  parameter CW          = 16
)(
  input  wire          core_clk,
  input  wire          reset_n,
  input  wire          vfc_pulse,
  input  wire          vfc_discharge,
  input  wire [4:0]    sense_mag,
  input  wire [11:0]   die_temp_q4,
  input  wire          single_wire_line,
  input  wire          pack_present_in,
  input  wire          wr_mode,
  input  wire          wr_sleep_allow,
  input  wire [2:0]    wr_wake_threshold_sel,
  input  wire          wr_clear,
  input  wire [4:0]    wr_clear_bits,
  output reg  [CW-1:0] discharge_accum,
  output reg  [CW-1:0] charge_accum,
  output reg  [CW-1:0] self_discharge_accum,
  output reg  [15:0]   discharge_time_count,
  output reg  [15:0]   charge_time_count,
  output reg           discharge_timer_overflow_flag,
  output reg           charge_timer_overflow_flag,
  output reg           sleep_allow,
  output reg  [2:0]    wake_threshold_sel,
  output reg  [4:0]    counter_clear_reg,
  output reg  [11:0]   temp_reg,
  output reg           sleeping,
  output reg           cal_strobe
);
  // clear bit positions: discharge, charge, self, dtime, ctime
  localparam CLR_D = 0, CLR_C = 1, CLR_S = 2, CLR_DT = 3, CLR_CT = 4;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage read only by the second; the line resets to
  // its pulled-up idle level so leaving reset shows no false edge
  reg       line_s1_q, line_s2_q, pack_s1_q, pack_s2_q;
  reg       line_prev_q, pack_prev_q;
  wire      line_edge = line_s2_q ^ line_prev_q;
  wire      pack_fall = pack_prev_q & ~pack_s2_q;
  wire      pack_rise = ~pack_prev_q & pack_s2_q;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_s1_q   <= 1'b1;
      line_s2_q   <= 1'b1;
      pack_s1_q   <= 1'b1;
      pack_s2_q   <= 1'b1;
      line_prev_q <= 1'b1;
      pack_prev_q <= 1'b1;
    end
    else
    begin
      line_s1_q   <= single_wire_line;
      line_s2_q   <= line_s1_q;
      line_prev_q <= line_s2_q;
      pack_s1_q   <= pack_present_in;
      pack_s2_q   <= pack_s1_q;
      pack_prev_q <= pack_s2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // base tick every 0.8789 s; hour tick every hour
  reg  [31:0] tick_cnt_q;
  reg  [39:0] hour_cnt_q;
  wire        tc_tick   = (tick_cnt_q == TC_CYCLES - 1);
  wire        hour_tick = (hour_cnt_q == HOUR_CYCLES - 1);
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt_q <= 32'h0;
      hour_cnt_q <= 40'h0;
      cal_strobe <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tc_tick ? 32'h0 : tick_cnt_q + 32'h1;
      hour_cnt_q <= hour_tick ? 40'h0 : hour_cnt_q + 40'h1;
      // offset calibration runs hourly, awake or asleep
      cal_strobe <= hour_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode register and clear register; a host set beats the hardware return to zero
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sleep_allow        <= `CCSC_SLEEP_ALLOW_RESET;
      wake_threshold_sel <= `CCSC_WAKE_SEL_RESET;
      counter_clear_reg  <= 5'h00;
    end
    else
    begin
      if (wr_mode)
      begin
        sleep_allow        <= wr_sleep_allow;
        wake_threshold_sel <= wr_wake_threshold_sel;
      end
      // a clear acts in one cycle, so the bit reads one for one cycle
      counter_clear_reg <= wr_clear ? wr_clear_bits : 5'h00;
    end
  end
  wire [4:0] clr = counter_clear_reg;

  //////////////////////////////////////////////////////////////////////////////
  // charge and discharge accumulators, frozen asleep
  wire awake  = ~sleeping;
  wire dis_p  = vfc_pulse & vfc_discharge & awake;
  wire chg_p  = vfc_pulse & ~vfc_discharge & awake;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      discharge_accum <= {CW{1'b0}};
      charge_accum    <= {CW{1'b0}};
    end
    else
    begin
      if (clr[CLR_D])
        discharge_accum <= {CW{1'b0}};
      else if (dis_p)
        discharge_accum <= discharge_accum + 1'b1;
      if (clr[CLR_C])
        charge_accum <= {CW{1'b0}};
      else if (chg_p)
        charge_accum <= charge_accum + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // direction held from last pulse; time counters with slow prescaler
  reg       dir_dis_q, dir_chg_q;
  reg [7:0] dslow_q, cslow_q;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dir_dis_q <= 1'b0;
      dir_chg_q <= 1'b0;
    end
    else if (vfc_pulse)
    begin
      dir_dis_q <= vfc_discharge;
      dir_chg_q <= ~vfc_discharge;
    end
    else if (tc_tick)
    begin
      // no pulse in a whole tick means no current in either direction
      dir_dis_q <= 1'b0;
      dir_chg_q <= 1'b0;
    end
  end

  wire dstep = tc_tick & dir_dis_q & awake &
               (~discharge_timer_overflow_flag | (dslow_q == 8'hFF));
  wire cstep = tc_tick & dir_chg_q & awake &
               (~charge_timer_overflow_flag | (cslow_q == 8'hFF));
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      discharge_time_count          <= 16'h0000;
      charge_time_count             <= 16'h0000;
      discharge_timer_overflow_flag <= 1'b0;
      charge_timer_overflow_flag    <= 1'b0;
      dslow_q                       <= 8'h00;
      cslow_q                       <= 8'h00;
    end
    else
    begin
      if (clr[CLR_DT])
      begin
        discharge_time_count          <= 16'h0000;
        discharge_timer_overflow_flag <= 1'b0;
        dslow_q                       <= 8'h00;
      end
      else
      begin
        if (tc_tick & dir_dis_q & awake & discharge_timer_overflow_flag)
          dslow_q <= dslow_q + 8'h01;
        if (dstep)
        begin
          discharge_time_count <= discharge_time_count + 16'h0001;
          if (discharge_time_count == 16'hFFFF)
            discharge_timer_overflow_flag <= 1'b1;
        end
      end
      if (clr[CLR_CT])
      begin
        charge_time_count          <= 16'h0000;
        charge_timer_overflow_flag <= 1'b0;
        cslow_q                    <= 8'h00;
      end
      else
      begin
        if (tc_tick & dir_chg_q & awake & charge_timer_overflow_flag)
          cslow_q <= cslow_q + 8'h01;
        if (cstep)
        begin
          charge_time_count <= charge_time_count + 16'h0001;
          if (charge_time_count == 16'hFFFF)
            charge_timer_overflow_flag <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // self-discharge: an eight-hour frame split into 64 slots; 2^exp slots count per frame
  // exp = 3 (one count per hour) at 25 C, +1 per 10 C up to 60 C, -1 per 10 C down to 0 C
  // coarse steps are a trade-off: rate doubles exactly per step, but only in 10 C bands
  reg  [5:0] sd_slot_q;
  reg  [2:0] sd_exp;
  wire [39:0] slot_len = HOUR_CYCLES / 8;
  reg  [39:0] slot_cnt_q;
  wire        slot_tick = (slot_cnt_q == slot_len - 1);
  always @*
  begin
    if (die_temp_q4 >= `CCSC_TQ_60C - `CCSC_TQ_10DEG / 2)
      sd_exp = 3'd6;
    else if (die_temp_q4 >= `CCSC_TQ_25C + `CCSC_TQ_10DEG * 2)
      sd_exp = 3'd5;
    else if (die_temp_q4 >= `CCSC_TQ_25C + `CCSC_TQ_10DEG)
      sd_exp = 3'd4;
    else if (die_temp_q4 >= `CCSC_TQ_25C)
      sd_exp = 3'd3;
    else if (die_temp_q4 >= `CCSC_TQ_25C - `CCSC_TQ_10DEG)
      sd_exp = 3'd2;
    else if (die_temp_q4 >= `CCSC_TQ_0C + `CCSC_TQ_10DEG / 2)
      sd_exp = 3'd1;
    else
      sd_exp = 3'd0;
  end
  // a slot counts when its low (6-exp) bits are zero: 2^exp slots per eight-hour frame
  wire [5:0] sd_mask = 6'h3F >> sd_exp;
  wire       sd_step = slot_tick & ((sd_slot_q & sd_mask) == 6'h00) & (sd_exp != 3'd0 | sd_slot_q == 6'h00);
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slot_cnt_q           <= 40'h0;
      sd_slot_q            <= 6'h00;
      self_discharge_accum <= {CW{1'b0}};
      temp_reg             <= 12'h000;
    end
    else
    begin
      slot_cnt_q <= slot_tick ? 40'h0 : slot_cnt_q + 40'h1;
      if (slot_tick)
        sd_slot_q <= sd_slot_q + 6'h01;
      // temperature and self-discharge keep running asleep
      temp_reg <= die_temp_q4;
      if (clr[CLR_S])
        self_discharge_accum <= {CW{1'b0}};
      else if (sd_step)
        self_discharge_accum <= self_discharge_accum + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sleep control
  wire        below_thr = (wake_threshold_sel != `CCSC_WAKE_SEL_OFF) &&
                          ({1'b0, sense_mag} < {3'h0, 3'h0 - wake_threshold_sel});
  reg  [39:0] idle_cnt_q;
  reg         asleep_at_fall_q;
  wire        idle_hour = (idle_cnt_q == HOUR_CYCLES - 1);
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_cnt_q       <= 40'h0;
      sleeping         <= 1'b0;
      asleep_at_fall_q <= 1'b0;
    end
    else
    begin
      idle_cnt_q <= (line_edge | ~below_thr | idle_hour) ? 40'h0 : idle_cnt_q + 40'h1;
      if (pack_fall)
      begin
        asleep_at_fall_q <= sleeping;
        sleeping         <= 1'b1;
      end
      else if (!pack_s2_q)
        sleeping <= 1'b1;
      else if (pack_rise)
        sleeping <= ~(~sleep_allow | ~asleep_at_fall_q);
      else if (sleeping & line_edge)
        sleeping <= 1'b0;
      else if (~sleeping & sleep_allow & idle_hour)
        sleeping <= 1'b1;
    end
  end
endmodule

// >>> sim/ccsc_top_asserts.sv
// Purpose: port-level checks for ccsc_top
// Assumes: one clock, async active-low reset
// Notes:   bound into every ccsc_top instance
`timescale 1ns/100ps
module ccsc_top_asserts #(parameter TC_CYCLES = 10, HOUR_CYCLES = 640, CW = 16) (
  input wire          core_clk,
  input wire          reset_n,
  input wire          vfc_pulse,
  input wire          vfc_discharge,
  input wire          single_wire_line,
  input wire          pack_present_in,
  input wire          wr_mode,
  input wire          wr_sleep_allow,
  input wire [2:0]    wr_wake_threshold_sel,
  input wire          wr_clear,
  input wire [4:0]    wr_clear_bits,
  input wire [CW-1:0] discharge_accum,
  input wire [CW-1:0] charge_accum,
  input wire [15:0]   charge_time_count,
  input wire          charge_timer_overflow_flag,
  input wire          sleep_allow,
  input wire [2:0]    wake_threshold_sel,
  input wire [4:0]    counter_clear_reg,
  input wire          sleeping
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // counts: a pulse lands next cycle on its own side only
  AST_DIS_CNT: assert property (vfc_pulse && vfc_discharge && !sleeping && counter_clear_reg == 5'h00
    |=> discharge_accum == $past(discharge_accum) + 1'b1 && $stable(charge_accum)) else $error("dis count");
  AST_CHG_CNT: assert property (vfc_pulse && !vfc_discharge && !sleeping && counter_clear_reg == 5'h00
    |=> charge_accum == $past(charge_accum) + 1'b1 && $stable(discharge_accum)) else $error("chg count");
  AST_SLEEP_FRZ: assert property (sleeping && counter_clear_reg == 5'h00
    |=> $stable(charge_accum) && $stable(discharge_accum)) else $error("count in sleep");
  // wrap of the timer raises its flag; clears win and drop it
  AST_WRAP: assert property (charge_time_count == 16'hFFFF && !counter_clear_reg[4] ##1 charge_time_count == 16'h0000
    |-> charge_timer_overflow_flag) else $error("wrap flag");
  AST_CLR_PULSE: assert property (wr_clear ##1 !wr_clear |-> counter_clear_reg == $past(wr_clear_bits)
    ##1 counter_clear_reg == 5'h00) else $error("clear bits");
  AST_CLR_CTC: assert property (wr_clear && wr_clear_bits[4] |-> ##2
    !charge_timer_overflow_flag && charge_time_count == 16'h0000) else $error("ctime clear");
  AST_MODE_WR: assert property (wr_mode |=> sleep_allow == $past(wr_sleep_allow)
    && wake_threshold_sel == $past(wr_wake_threshold_sel)) else $error("mode write");
  // power states: synchroniser latency allowed for
  AST_PACK_LOW: assert property (!pack_present_in [*5] |-> sleeping) else $error("pack sleep");
  AST_LINE_WAKE: assert property (sleeping && pack_present_in && $changed(single_wire_line)
    |-> ##[1:5] !sleeping) else $error("line wake");
  cover property ($rose(charge_timer_overflow_flag));
  cover property ($rose(sleeping));
  cover property ($fell(sleeping));
endmodule
bind ccsc_top ccsc_top_asserts #(.TC_CYCLES(TC_CYCLES), .HOUR_CYCLES(HOUR_CYCLES), .CW(CW)) u_chk (.*);

// >>> sim/ccsc_host_model.sv
// Purpose: host side of the single-wire link
// Assumes: line has a pull-up and idles high
// Notes:   drives 5 ns after a core_clk edge
`timescale 1ns/100ps
module ccsc_host_model (
  input  wire       core_clk,
  input  wire       pack_present_in,
  output reg        single_wire_line,
  output reg        wr_clear,
  output reg  [4:0] wr_clear_bits
);
  initial
  begin
    single_wire_line = 1'b1;
    wr_clear = 1'b0;
    wr_clear_bits = 5'h00;
  end
  ////////////////////////////////////////////////////////////
  // one-cycle clear; bits go stale-inverted once released
  task clear(input [4:0] bits);
  begin
    @(posedge core_clk) #5 wr_clear = 1'b1;
    wr_clear_bits = bits;
    @(posedge core_clk) #5 wr_clear = 1'b0;
    wr_clear_bits = ~bits;
  end
  endtask
  // after pack return, pull the line low briefly so wake completes
  always @(posedge pack_present_in)
  begin
    repeat (20) @(posedge core_clk);
    #5 single_wire_line = 1'b0;
    repeat (4) @(posedge core_clk);
    #5 single_wire_line = 1'b1;
  end
endmodule

// >>> sim/charge_count_sleep_control_tb.sv
// Purpose: self-checking bench for ccsc_top
// Assumes: shortened tick and hour parameters
// Notes:   host model does clears and line pulses
`timescale 1ns/100ps
`include "ccsc_defines.vh"
module charge_count_sleep_control_tb;
  localparam HR = 640;
  reg         core_clk, reset_n, vfc_pulse, vfc_discharge, pack_present_in, wr_mode, wr_sleep_allow;
  reg  [4:0]  sense_mag;
  reg  [11:0] die_temp_q4;
  reg  [2:0]  wr_wake_threshold_sel;
  wire        single_wire_line, wr_clear, discharge_timer_overflow_flag, charge_timer_overflow_flag;
  wire        sleep_allow, sleeping, cal_strobe;
  wire [4:0]  wr_clear_bits, counter_clear_reg;
  wire [2:0]  wake_threshold_sel;
  wire [11:0] temp_reg;
  wire [15:0] discharge_accum, charge_accum, self_discharge_accum, discharge_time_count, charge_time_count;
  integer     err_count, checked, i;
  reg  [15:0] a, sd [0:2];
  // tick every cycle so a wrap fits the run
  ccsc_top #(.TC_CYCLES(1), .HOUR_CYCLES(HR)) dut (.*);
  ccsc_host_model host (.*);
  ////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // watchdog: run needs about 78k cycles
  initial
  begin
    repeat (95000) @(posedge core_clk);
    err_count = err_count + 1;
    print_verdict;
  end
  task step(input integer n);
  begin
    repeat (n) @(posedge core_clk);
    #5;
  end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    if (got !== exp)
      err_count = err_count + 1;
  end
  endtask
  task pulses(input dis, input integer n);
  begin
    vfc_discharge = dis;
    vfc_pulse = 1'b1;
    step(n);
    vfc_pulse = 1'b0;
  end
  endtask
  task mode(input sa, input [2:0] code);
  begin
    {wr_mode, wr_sleep_allow, wr_wake_threshold_sel} = {1'b1, sa, code};
    step(1);
    wr_mode = 1'b0;
    step(1);
  end
  endtask
  task print_verdict;
  begin
    $display("checked %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {err_count, checked} = 0;
    {reset_n, vfc_pulse, vfc_discharge, wr_mode, wr_sleep_allow, wr_wake_threshold_sel} = 8'h00;
    {sense_mag, die_temp_q4, pack_present_in} = {5'h1F, `CCSC_TQ_25C, 1'b1};
    step(6);
    reset_n = 1'b1;
    chk(sleep_allow, 1'b1);
    chk(wake_threshold_sel, 3'h7);
    pulses(1'b1, 3);
    step(1);
    pulses(1'b0, 2);
    step(4);
    chk(discharge_accum, 16'h0003);
    chk(charge_accum, 16'h0002);
    chk(discharge_time_count != 16'h0000, 1'b1);
    host.clear(5'h1F);
    chk(counter_clear_reg, 5'h1F);
    step(1);
    chk(counter_clear_reg, 5'h00);
    chk(charge_accum, 16'h0000);
    $display("t1 done");
    // charge until the timer wraps, then the slow rate
    vfc_discharge = 1'b0;
    vfc_pulse = 1'b1;
    for (i = 0; i < 70000 && charge_timer_overflow_flag !== 1'b1; i = i + 1)
      step(1);
    chk(charge_time_count, 16'h0000);
    step(600);
    a = charge_time_count;
    chk(a, 16'h0002);
    chk(discharge_time_count, 16'h0000);
    vfc_pulse = 1'b0;
    host.clear(5'h10);
    step(1);
    chk(charge_timer_overflow_flag, 1'b0);
    $display("t2 done");
    // self-discharge from an hour mark: two hours at 25 and 45 C, eight at 5 C
    for (i = 0; i < 3; i = i + 1)
    begin
      die_temp_q4 = (i == 0) ? `CCSC_TQ_25C : (i == 1) ? `CCSC_TQ_25C + 12'h050 : `CCSC_TQ_25C - 12'h050;
      host.clear(5'h04);
      step(1);
      chk(self_discharge_accum, 16'h0000);
      while (cal_strobe !== 1'b1)
        step(1);
      a = self_discharge_accum;
      step((i == 2) ? 8 * HR : 2 * HR);
      sd[i] = self_discharge_accum - a;
      chk(cal_strobe, 1'b1);
      chk(temp_reg, die_temp_q4);
      step(1);
      chk(cal_strobe, 1'b0);
    end
    chk(sd[0], 16'h0002);
    chk(sd[1], 16'h0008);
    chk(sd[2], 16'h0002);
    $display("t3 done");
    // every threshold code, then pack removal with allow clear
    for (i = 0; i < 8; i = i + 1)
    begin
      mode(1'b0, i[2:0]);
      chk(wake_threshold_sel, i[2:0]);
    end
    pack_present_in = 1'b0;
    step(6);
    chk(sleeping, 1'b1);
    a = discharge_accum;
    pulses(1'b1, 2);
    step(2);
    chk(discharge_accum, a);
    pack_present_in = 1'b1;
    step(6);
    chk(sleeping, 1'b0);
    step(40);
    $display("t4 done");
    // idle sleep at the threshold edge, pack cycle while asleep
    mode(1'b1, 3'h7);
    sense_mag = 5'h01;
    step(HR + 60);
    chk(sleeping, 1'b0);
    sense_mag = 5'h00;
    for (i = 0; i < HR + 60 && sleeping !== 1'b1; i = i + 1)
      step(1);
    chk(sleeping, 1'b1);
    pack_present_in = 1'b0;
    step(6);
    pack_present_in = 1'b1;
    step(6);
    chk(sleeping, 1'b1);
    step(30);
    chk(sleeping, 1'b0);
    $display("t5 done");
    print_verdict;
  end
endmodule
